//--- src/lin_ctrl_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  transceiver mode and protection controller.
  Assumes a 200 MHz system clock.
*/
`ifndef LIN_CTRL_DEFS_SVH
`define LIN_CTRL_DEFS_SVH
// Register indices; byte address is four times the index
`define IDX_MODE 8'h0b
`define IDX_STAT 8'h0c
// Mode register fields
`define MODE_SEL_HI 7
`define MODE_SEL_LO 6
`define MODE_LIMP_DIS 5
`define MODE_RST_WD 2
`define MODE_FS_EN 1
`define MODE_DTO_DIS 0
`define MODE_RESET 8'h00
`define MSEL_NORMAL 2'b10
`define MSEL_SLEEP 2'b01
`define MSEL_STANDBY_STATE 2'b00
// Status register fields
`define STAT_DTO 3
`define STAT_LOCK 4
`define STAT_SERIAL 5
`define STAT_ATTN 6
// Timing
`define CLK_PERIOD_NS 5
`define DOM_TIMEOUT_US 1000
`define RST_PULSE_US 2000
`define DTO_CYCLES ((`DOM_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define RST_CYCLES ((`RST_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- src/lin_ctrl_pkg.sv
/*
  Types of the transceiver mode and protection controller.
  Assumes nothing of its surroundings.
*/
package lin_ctrl_pkg;
  // Device operating states
  typedef enum logic [2:0] {
    S_POR, S_SLEEP, S_STANDBY_STATE, S_NORM, S_TSD, S_FSAFE
  } mode_t;
endpackage

//--- src/lin_mode_protect_ctrl.sv
/*
  Mode and protection controller of a single-wire bus transceiver:
  operating states, pin states, dominant timeout, wake lockout,
  thermal handling, reset pin and the enable/attention pin.
  Assumes an AHB-Lite master, filtered analog status inputs and a
  testbench that resolves the open-drain pins from their enables.
*/
`timescale 1ns/1ps
`include "lin_ctrl_defs.svh"

// How it works
// - Pin config: enable high gives normal mode, low in normal gives sleep.
// - Normal mode is entered only from standby or at power-up, never straight from sleep.
// - An undriven enable input reads as low.
// - Serial config: enable pin is an active-low attention output.
// - Standby or normal: reset pin is low while the regulated rail is undervolted, unless mode bit 2 selects the watchdog pulse.
// - Thermal shutdown drives the reset pin low.
// - Serial config: reset pin may give a watchdog pulse of fixed length.
// - Transmit held low past the timeout disables the transmitter.
// - Rising transmit input clears the timeout fault and its timer.
// - During the timeout fault mode, receive and termination stay.
// - Serial config: mode bit 0 disables the dominant timeout.
// - Transmit input defaults high, giving a recessive bus.
// - Bus dominant at sleep entry locks out bus wake until recessive.
// - Thermal: transmitter recessive, regulator off, thermal-off, then standby.
// - Failsafe enabled: thermal leads to failsafe with limp-home on.
// - Battery undervoltage holds the device inactive.
// - Sleep pin states: receive and reset float, weak pull-up only.
// - Standby pin states: receive low, termination on, limp held.
// - Normal: receive carries bus data, transmitter and watchdog run.
// - Failsafe uses sleep pin states with limp-home on.
// - Thermal-off: receive floats, reset driven low, transmitter and watchdog off.
// - Control-select pin sampled once at power-up; low means pin config.
// - Power-up pin config: enable high gives normal, low gives standby.
// - Serial mode field: 10 normal, 01 sleep, 00 standby from normal.
// - Bus wake in standby is shown by receive low until normal.
module lin_mode_protect_ctrl #(
  parameter int unsigned DTO_CYCLES = `DTO_CYCLES,
  parameter int unsigned RST_CYCLES = `RST_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Host side pins
  input wire logic I_TXD,
  output logic O_RXD_O,
  output logic O_RXD_OE,
  input wire logic I_EN_PIN,
  output logic O_EN_PIN_O,
  output logic O_EN_PIN_OE,
  output logic O_RAIL_RESET_N_O,
  output logic O_RAIL_RESET_N_OE,
  input wire logic I_CTRL_SELECT_OR_CHIP_SEL,
  // Bus side
  input wire logic I_BUS_LVL,
  output logic O_BUS_DRIVE,
  output logic O_BUS_TERM_EN,
  output logic O_BUS_WEAK_PU,
  // Analog monitors and other blocks
  input wire logic I_BATTERY_UNDERVOLT,
  input wire logic I_RAIL_UNDERVOLT,
  input wire logic I_THERMAL_SHUTDOWN,
  input wire logic I_LOCAL_WAKE,
  input wire logic I_WDOG_EXPIRE,
  input wire logic I_WDOG_LIMP,
  output logic O_REG_EN,
  output logic O_WDOG_RUN,
  output logic O_SERIAL_PINS_EN,
  output logic O_LIMP_ON,
  output logic [2:0] O_STATE
);
  lin_ctrl_pkg::mode_t state_q, state_d;
  logic strap_done_q;
  logic cfg_serial_q;
  logic [7:0] mode_q;
  logic attn_q;
  logic ap_wr_q, ap_rd_q;
  logic [7:0] ap_idx_q;
  logic txd_prev_q;
  logic [19:0] dto_cnt_q;
  logic dto_fault_q;
  logic lock_q, dom_seen_q;
  logic [19:0] wd_cnt_q;
  logic therm_prev_q;
  logic limp_q;
  // Bus decode
  wire ap_take = I_HSEL & I_HREADY & I_HTRANS[1];
  wire ap_map = (I_HADDR[31:10] == 22'h000000);
  wire [7:0] ap_idx = I_HADDR[9:2];
  wire wr_mode = ap_wr_q & (ap_idx_q == `IDX_MODE);
  wire wr_stat = ap_wr_q & (ap_idx_q == `IDX_STAT);
  wire [1:0] msel = I_HWDATA[`MODE_SEL_HI:`MODE_SEL_LO];
  wire attn_clr = wr_stat & I_HWDATA[`STAT_ATTN];
  // Configuration derived controls
  wire en_lvl = I_EN_PIN & ~cfg_serial_q;
  wire dto_dis = cfg_serial_q & mode_q[`MODE_DTO_DIS];
  wire fs_en = cfg_serial_q & mode_q[`MODE_FS_EN];
  wire rst_wd = cfg_serial_q & mode_q[`MODE_RST_WD];
  wire limp_dis = cfg_serial_q & mode_q[`MODE_LIMP_DIS];
  wire ser_wr = wr_mode & cfg_serial_q;
  // Transmit edges
  wire txd_fall = txd_prev_q & ~I_TXD;
  wire txd_rise = ~txd_prev_q & I_TXD;
  wire dto_hit = (dto_cnt_q == 20'(DTO_CYCLES - 1));
  // Wake sources
  wire bus_wake = dom_seen_q & I_BUS_LVL & ~lock_q;
  wire wake_any = I_LOCAL_WAKE | bus_wake | en_lvl;
  wire is_sleep = (state_q == lin_ctrl_pkg::S_SLEEP);
  wire enter_sleep = (state_d == lin_ctrl_pkg::S_SLEEP) & ~is_sleep;
  // Next state
  always_comb begin
    state_d = state_q;
    if (I_BATTERY_UNDERVOLT) begin
      state_d = lin_ctrl_pkg::S_POR;
    end else if (I_THERMAL_SHUTDOWN && state_q != lin_ctrl_pkg::S_POR) begin
      state_d = fs_en ? lin_ctrl_pkg::S_FSAFE : lin_ctrl_pkg::S_TSD;
    end else begin
      unique case (state_q)
        lin_ctrl_pkg::S_POR: begin
          if (strap_done_q) begin
            if (!cfg_serial_q && en_lvl) begin
              state_d = lin_ctrl_pkg::S_NORM;
            end else begin
              state_d = lin_ctrl_pkg::S_STANDBY_STATE;
            end
          end
        end
        lin_ctrl_pkg::S_SLEEP: begin
          if (wake_any) begin
            state_d = lin_ctrl_pkg::S_STANDBY_STATE;
          end
        end
        lin_ctrl_pkg::S_STANDBY_STATE: begin
          if (!cfg_serial_q && en_lvl) begin
            state_d = lin_ctrl_pkg::S_NORM;
          end else if (ser_wr && msel == `MSEL_NORMAL) begin
            state_d = lin_ctrl_pkg::S_NORM;
          end else if (ser_wr && msel == `MSEL_SLEEP) begin
            state_d = lin_ctrl_pkg::S_SLEEP;
          end
        end
        lin_ctrl_pkg::S_NORM: begin
          if (!cfg_serial_q && !en_lvl) begin
            state_d = lin_ctrl_pkg::S_SLEEP;
          end else if (ser_wr && msel == `MSEL_SLEEP) begin
            state_d = lin_ctrl_pkg::S_SLEEP;
          end else if (ser_wr && msel == `MSEL_STANDBY_STATE) begin
            state_d = lin_ctrl_pkg::S_STANDBY_STATE;
          end
        end
        lin_ctrl_pkg::S_TSD: begin
          state_d = lin_ctrl_pkg::S_STANDBY_STATE;
        end
        lin_ctrl_pkg::S_FSAFE: begin
          if (wake_any) begin
            state_d = lin_ctrl_pkg::S_STANDBY_STATE;
          end
        end
        default: begin
          state_d = lin_ctrl_pkg::S_POR;
        end
      endcase
    end
  end
  // Pin states of the next state
  wire n_norm = (state_d == lin_ctrl_pkg::S_NORM);
  wire n_standby_state = (state_d == lin_ctrl_pkg::S_STANDBY_STATE);
  wire n_fs = (state_d == lin_ctrl_pkg::S_FSAFE);
  wire n_lowp = (state_d == lin_ctrl_pkg::S_SLEEP) | n_fs;
  wire n_act = n_norm | n_standby_state;
  wire tx_d = n_norm & ~I_TXD & ~dto_fault_q & ~(dto_hit & ~I_TXD & ~dto_dis);
  wire rxd_oe_d = n_standby_state | (n_norm & ~I_BUS_LVL);
  wire limp_d = n_fs | (n_norm & I_WDOG_LIMP & ~limp_dis) | (n_standby_state & limp_q);
  wire wd_low = rst_wd ? (wd_cnt_q != 20'h00000) : I_RAIL_UNDERVOLT;
  wire rst_low_d = I_THERMAL_SHUTDOWN | (n_act & wd_low);
  // Strap capture after reset release
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      strap_done_q <= 1'b0;
      cfg_serial_q <= 1'b0;
    end else if (!strap_done_q && !I_BATTERY_UNDERVOLT) begin
      strap_done_q <= 1'b1;
      cfg_serial_q <= I_CTRL_SELECT_OR_CHIP_SEL;
    end
  end
  // State register
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_q <= lin_ctrl_pkg::S_POR;
    end else begin
      state_q <= state_d;
    end
  end
  // Bus address phase capture
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_idx_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_take & I_HWRITE & ap_map;
      ap_rd_q <= ap_take & ~I_HWRITE;
      ap_idx_q <= ap_map ? ap_idx : 8'hff;
    end
  end
  // Read data, one wait state per read
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_HRDATA <= 32'h00000000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
      O_HREADYOUT <= ~(ap_take & ~I_HWRITE);
      if (ap_rd_q && ap_idx_q == `IDX_MODE) begin
        O_HRDATA <= {24'h000000, mode_q};
      end else if (ap_rd_q && ap_idx_q == `IDX_STAT) begin
        O_HRDATA <= {25'h0000000, attn_q, cfg_serial_q, lock_q, dto_fault_q, 3'(state_q)};
      end else if (ap_rd_q) begin
        O_HRDATA <= 32'h00000000;
      end
    end
  end
  // Mode register
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= `MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= I_HWDATA[7:0];
    end
  end
  // Attention flag, a new event wins over a clear
  wire attn_set = (wake_any & (is_sleep | state_q == lin_ctrl_pkg::S_FSAFE))
    | (I_THERMAL_SHUTDOWN & ~therm_prev_q) | (dto_hit & ~dto_fault_q & ~I_TXD);
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      attn_q <= 1'b0;
      therm_prev_q <= 1'b0;
    end else begin
      attn_q <= attn_set | (attn_q & ~attn_clr);
      therm_prev_q <= I_THERMAL_SHUTDOWN;
    end
  end
  // Dominant timeout timer
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      txd_prev_q <= 1'b1;
      dto_cnt_q <= 20'h00000;
      dto_fault_q <= 1'b0;
    end else begin
      txd_prev_q <= I_TXD;
      if (state_q != lin_ctrl_pkg::S_NORM || txd_rise || dto_dis || I_TXD) begin
        dto_cnt_q <= 20'h00000;
        dto_fault_q <= 1'b0;
      end else if (!dto_fault_q) begin
        dto_cnt_q <= dto_cnt_q + 20'h00001;
        dto_fault_q <= dto_hit;
      end
    end
  end
  // Stuck-dominant wake lockout
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      lock_q <= 1'b0;
      dom_seen_q <= 1'b0;
    end else if (enter_sleep) begin
      lock_q <= ~I_BUS_LVL;
      dom_seen_q <= 1'b0;
    end else if (is_sleep) begin
      lock_q <= lock_q & ~I_BUS_LVL;
      dom_seen_q <= (dom_seen_q | ~I_BUS_LVL) & ~lock_q & ~bus_wake;
    end else begin
      lock_q <= 1'b0;
      dom_seen_q <= 1'b0;
    end
  end
  // Watchdog reset pulse
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      wd_cnt_q <= 20'h00000;
    end else if (rst_wd && I_WDOG_EXPIRE && wd_cnt_q == 20'h00000) begin
      wd_cnt_q <= 20'(RST_CYCLES);
    end else if (wd_cnt_q != 20'h00000) begin
      wd_cnt_q <= wd_cnt_q - 20'h00001;
    end
  end
  // Registered pin outputs
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_BUS_DRIVE <= 1'b0;
      O_BUS_TERM_EN <= 1'b0;
      O_BUS_WEAK_PU <= 1'b0;
      O_RXD_O <= 1'b0;
      O_RXD_OE <= 1'b0;
      O_EN_PIN_O <= 1'b0;
      O_EN_PIN_OE <= 1'b0;
      O_RAIL_RESET_N_O <= 1'b0;
      O_RAIL_RESET_N_OE <= 1'b1;
      O_REG_EN <= 1'b0;
      O_WDOG_RUN <= 1'b0;
      O_SERIAL_PINS_EN <= 1'b0;
      O_LIMP_ON <= 1'b0;
      limp_q <= 1'b0;
      O_STATE <= 3'h0;
    end else begin
      O_BUS_DRIVE <= tx_d & ~I_THERMAL_SHUTDOWN;
      O_BUS_TERM_EN <= n_act | (state_d == lin_ctrl_pkg::S_TSD);
      O_BUS_WEAK_PU <= n_lowp;
      O_RXD_O <= 1'b0;
      O_RXD_OE <= rxd_oe_d;
      O_EN_PIN_O <= 1'b0;
      O_EN_PIN_OE <= cfg_serial_q & attn_q;
      O_RAIL_RESET_N_O <= ~rst_low_d;
      O_RAIL_RESET_N_OE <= rst_low_d | n_act;
      O_REG_EN <= n_act;
      O_WDOG_RUN <= n_norm;
      O_SERIAL_PINS_EN <= n_act | (state_d == lin_ctrl_pkg::S_TSD);
      O_LIMP_ON <= limp_d;
      limp_q <= limp_d;
      O_STATE <= 3'(state_d);
    end
  end
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  sequence s_txd_low;
    txd_prev_q && !I_TXD;
  endsequence
  sequence s_txd_high;
    !txd_prev_q && I_TXD;
  endsequence
  property p_sleep_pins;
    is_sleep |-> !O_BUS_DRIVE && !O_RXD_OE && O_BUS_WEAK_PU && !O_BUS_TERM_EN && !O_RAIL_RESET_N_OE;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pin state wrong");
  property p_norm_after_wake;
    (state_q == lin_ctrl_pkg::S_NORM && $past(state_q) != lin_ctrl_pkg::S_NORM)
      |-> ($past(state_q) == lin_ctrl_pkg::S_STANDBY_STATE || $past(state_q) == lin_ctrl_pkg::S_POR);
  endproperty
  a_norm_after_wake: assert property (p_norm_after_wake) else $error("normal entered without wake");
  property p_dto_trip;
    (state_q == lin_ctrl_pkg::S_NORM && !dto_dis && !I_TXD && dto_hit && !dto_fault_q)
      |=> dto_fault_q && !O_BUS_DRIVE;
  endproperty
  a_dto_trip: assert property (p_dto_trip) else $error("timeout did not stop transmitter");
  property p_dto_clear;
    s_txd_low ##[1:8] s_txd_high |=> !dto_fault_q && dto_cnt_q == 20'h00000;
  endproperty
  a_dto_clear: assert property (p_dto_clear) else $error("rising transmit did not clear timeout");
  property p_dto_stay;
    (dto_fault_q && state_q == lin_ctrl_pkg::S_NORM) |-> O_BUS_TERM_EN && O_WDOG_RUN;
  endproperty
  a_dto_stay: assert property (p_dto_stay) else $error("timeout fault left normal pins");
  property p_therm_rst;
    I_THERMAL_SHUTDOWN |=> O_RAIL_RESET_N_OE && !O_RAIL_RESET_N_O && !O_BUS_DRIVE;
  endproperty
  a_therm_rst: assert property (p_therm_rst) else $error("thermal did not pull reset low");
  property p_wd_pulse;
    (rst_wd && I_WDOG_EXPIRE && wd_cnt_q == 20'h00000) |=> wd_cnt_q == 20'(RST_CYCLES);
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse length wrong");
  property p_lockout;
    (enter_sleep && !I_BUS_LVL) |=> lock_q ##0 !bus_wake;
  endproperty
  a_lockout: assert property (p_lockout) else $error("dominant bus did not lock wake");
  property p_tsd_off;
    (I_THERMAL_SHUTDOWN && !I_BATTERY_UNDERVOLT && !fs_en && state_q != lin_ctrl_pkg::S_POR)
      |=> state_q == lin_ctrl_pkg::S_TSD && !O_REG_EN;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("thermal-off not entered");
  property p_fsafe;
    (I_THERMAL_SHUTDOWN && !I_BATTERY_UNDERVOLT && fs_en && state_q != lin_ctrl_pkg::S_POR)
      |=> state_q == lin_ctrl_pkg::S_FSAFE && O_LIMP_ON && O_BUS_WEAK_PU;
  endproperty
  a_fsafe: assert property (p_fsafe) else $error("failsafe not entered");
  property p_por_hold;
    I_BATTERY_UNDERVOLT |=> state_q == lin_ctrl_pkg::S_POR && !O_BUS_DRIVE && !O_REG_EN;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("undervolt did not hold device");
endmodule

//--- verif/lin_bus_partner.sv
/*
  Far-side model of the single-wire bus: a wired-and line with a pull-up.
  Assumes the design's bus drive output and a remote-node request from the bench.
*/
`timescale 1ns/1ps

module lin_bus_partner (
  // Pull requests
  input wire logic i_node_drive,
  input wire logic i_remote_dom,
  // Resolved line
  output logic o_bus_lvl
);
  // Recessive unless some node pulls dominant
  assign o_bus_lvl = ~(i_node_drive | i_remote_dom);
endmodule

//--- verif/tb_top.sv
/*
  Self-checking bench of the transceiver mode and protection controller.
  Assumes the design package and header, and the bus partner model.
*/
`timescale 1ns/1ps

module tb_top;
  localparam int DTO_P = 8;
  localparam int RST_P = 6;
  localparam logic [31:0] A_MODE = 32'h0000002c;
  localparam logic [31:0] A_STAT = 32'h00000030;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic txd_drv = 1'b1, txd_z = 1'b0, en_drv = 1'b0, en_z = 1'b1, strap = 1'b0, remote_dom = 1'b0;
  logic bat_uv = 1'b0, rail_uv = 1'b0, therm = 1'b0, lwake = 1'b0, wd_exp = 1'b0, wd_limp = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, rxd_o, rxd_oe, en_o, en_oe, rst_o, rst_oe, bus_drive, term_en, weak_pu;
  wire logic reg_en, wdog_run, ser_en, limp, bus_lvl;
  wire logic [2:0] state;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  integer seed = 32'hf91e;
  // Resolved pin levels: pull-up on transmit, reset and receive; enable pulled down in pin config, pulled up in serial config
  wire logic txd_lvl = txd_z ? 1'b1 : txd_drv;
  wire logic en_lvl = strap ? (en_oe ? en_o : 1'b1) : (en_z ? 1'b0 : en_drv);
  wire logic rxd_lvl = rxd_oe ? rxd_o : 1'b1;
  // Processor reset taken from limp-home by an external circuit
  wire logic ext_wdr_n = ~limp;
  wire logic rst_lvl = rst_oe ? rst_o : 1'b1;

  // Clock
  always #2.5 clk = ~clk;

  lin_mode_protect_ctrl #(.DTO_CYCLES(DTO_P), .RST_CYCLES(RST_P)) DUT (
    .I_CLK_SYS(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_TXD(txd_lvl),
    .O_RXD_O(rxd_o), .O_RXD_OE(rxd_oe), .I_EN_PIN(en_lvl), .O_EN_PIN_O(en_o),
    .O_EN_PIN_OE(en_oe), .O_RAIL_RESET_N_O(rst_o), .O_RAIL_RESET_N_OE(rst_oe),
    .I_CTRL_SELECT_OR_CHIP_SEL(strap), .I_BUS_LVL(bus_lvl), .O_BUS_DRIVE(bus_drive),
    .O_BUS_TERM_EN(term_en), .O_BUS_WEAK_PU(weak_pu), .I_BATTERY_UNDERVOLT(bat_uv),
    .I_RAIL_UNDERVOLT(rail_uv), .I_THERMAL_SHUTDOWN(therm), .I_LOCAL_WAKE(lwake),
    .I_WDOG_EXPIRE(wd_exp), .I_WDOG_LIMP(wd_limp), .O_REG_EN(reg_en), .O_WDOG_RUN(wdog_run),
    .O_SERIAL_PINS_EN(ser_en), .O_LIMP_ON(limp), .O_STATE(state)
  );

  lin_bus_partner u_bus (.i_node_drive(bus_drive), .i_remote_dom(remote_dom), .o_bus_lvl(bus_lvl));

  // Verdict and end of run
  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // Single AHB-Lite transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Reset with a given strap level
  task automatic do_reset(input logic sel);
    strap <= sel; rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Wait for a state, then compare it and its pin set {term, weak, wdog, limp, rxd}
  task automatic check_state(input lin_ctrl_pkg::mode_t s);
    logic [4:0] e;
    n = 0;
    while (state !== s && n < 30) begin @(posedge clk); n++; end
    repeat (2) @(posedge clk);
    case (s)
      lin_ctrl_pkg::S_SLEEP: e = 5'b01001;
      lin_ctrl_pkg::S_FSAFE: e = 5'b01011;
      lin_ctrl_pkg::S_STANDBY_STATE: e = 5'b10000;
      lin_ctrl_pkg::S_NORM: e = 5'b10101;
      default: e = 5'b10001;
    endcase
    chk("state", 32'(s), {29'h0, state});
    chk("pins", {27'h0, e}, {27'h0, term_en, weak_pu, wdog_run, limp, rxd_lvl});
  endtask

  // First state taken after leaving a given one
  task automatic next_state(input lin_ctrl_pkg::mode_t from, input lin_ctrl_pkg::mode_t to);
    n = 0;
    while (state === from && n < 30) begin @(posedge clk); n++; end
    chk("next", 32'(to), {29'h0, state});
  endtask

  // One-cycle pulse on the watchdog expiry or the local wake input
  task automatic pulse(input bit wd);
    if (wd) wd_exp <= 1'b1;
    else lwake <= 1'b1;
    @(posedge clk);
    wd_exp <= 1'b0;
    lwake <= 1'b0;
  endtask

  // Watchdog on a hang
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    do_reset(1'b0);
    check_state(lin_ctrl_pkg::S_STANDBY_STATE);
    en_z <= 1'b0; en_drv <= 1'b1;
    check_state(lin_ctrl_pkg::S_NORM);
    for (int i = 0; i < 12; i++) begin
      txd_drv <= 1'($random(seed)); remote_dom <= ($random(seed) & 3) == 0;
      repeat (3) @(posedge clk);
      chk("drive", {31'h0, ~txd_drv}, {31'h0, bus_drive});
      chk("rxd", {31'h0, bus_lvl}, {31'h0, rxd_lvl});
      txd_drv <= 1'b1; remote_dom <= 1'b0; @(posedge clk);
    end
    txd_drv <= 1'b0; txd_z <= 1'b1; repeat (3) @(posedge clk);
    chk("float_txd", 32'h0, {31'h0, bus_drive});
    txd_z <= 1'b0; repeat (DTO_P - 2) @(posedge clk);
    chk("dto_early", 32'h1, {31'h0, bus_drive});
    repeat (6) @(posedge clk);
    chk("dto_trip", 32'h0, {31'h0, bus_drive});
    check_state(lin_ctrl_pkg::S_NORM);
    txd_drv <= 1'b1; repeat (2) @(posedge clk); txd_drv <= 1'b0; repeat (3) @(posedge clk);
    chk("dto_clear", 32'h1, {31'h0, bus_drive});
    txd_drv <= 1'b1; rail_uv <= 1'b1; repeat (3) @(posedge clk);
    chk("rail_low", 32'h0, {31'h0, rst_lvl});
    rail_uv <= 1'b0; repeat (3) @(posedge clk);
    chk("rail_high", 32'h1, {31'h0, rst_lvl});
    en_drv <= 1'b0;
    check_state(lin_ctrl_pkg::S_SLEEP);
    chk("rst_float", 32'h0, {31'h0, rst_oe});
    en_drv <= 1'b1;
    next_state(lin_ctrl_pkg::S_SLEEP, lin_ctrl_pkg::S_STANDBY_STATE);
    check_state(lin_ctrl_pkg::S_NORM);
    txd_drv <= 1'b0; therm <= 1'b1;
    check_state(lin_ctrl_pkg::S_TSD);
    chk("tsd", 32'h0, {30'h0, bus_drive, reg_en});
    chk("tsd_rst", 32'h0, {31'h0, rst_lvl});
    txd_drv <= 1'b1; therm <= 1'b0;
    next_state(lin_ctrl_pkg::S_TSD, lin_ctrl_pkg::S_STANDBY_STATE);
    bat_uv <= 1'b1; repeat (3) @(posedge clk);
    chk("por", 32'h0, {28'h0, state, bus_drive});
    bat_uv <= 1'b0;
    check_state(lin_ctrl_pkg::S_NORM);
    do_reset(1'b1);
    ahb(1'b0, A_MODE, 32'h0); chk("mode_rst", 32'h0, rd);
    ahb(1'b0, A_STAT, 32'h0); chk("serial", 32'h1, {31'h0, rd[5]});
    ahb(1'b1, 32'h00000400, 32'hff); ahb(1'b0, 32'h00000400, 32'h0); chk("unmapped", 32'h0, rd);
    pulse(1'b0);
    ahb(1'b1, A_MODE, 32'h81);
    check_state(lin_ctrl_pkg::S_NORM);
    txd_drv <= 1'b0; repeat (DTO_P + 4) @(posedge clk);
    chk("dto_off", 32'h1, {31'h0, bus_drive});
    txd_drv <= 1'b1;
    ahb(1'b1, A_MODE, 32'h84);
    pulse(1'b1);
    n = 0;
    while (rst_lvl !== 1'b0 && n < 10) begin @(posedge clk); n++; end
    n = 0;
    while (rst_lvl === 1'b0 && n < 40) begin @(posedge clk); n++; end
    chk("wdog_low", RST_P, n);
    remote_dom <= 1'b1;
    ahb(1'b1, A_MODE, 32'h40);
    check_state(lin_ctrl_pkg::S_SLEEP);
    ahb(1'b0, A_STAT, 32'h0); chk("lock", 32'h1, {31'h0, rd[4]});
    chk("ser_off", 32'h0, {31'h0, ser_en});
    remote_dom <= 1'b0; repeat (3) @(posedge clk);
    ahb(1'b0, A_STAT, 32'h0); chk("unlock", 32'h0, {31'h0, rd[4]});
    pulse(1'b0);
    ahb(1'b1, A_MODE, 32'h82);
    check_state(lin_ctrl_pkg::S_NORM);
    ahb(1'b1, A_STAT, 32'h40); repeat (2) @(posedge clk);
    chk("attn_clr", 32'h1, {31'h0, en_lvl});
    wd_limp <= 1'b1;
    repeat (3) @(posedge clk);
    chk("limp_on", 32'h1, {31'h0, limp});
    ahb(1'b1, A_MODE, 32'h02);
    wd_limp <= 1'b0;
    repeat (3) @(posedge clk);
    chk("limp_held", 32'h1, {31'h0, limp});
    wd_limp <= 1'b1;
    ahb(1'b1, A_MODE, 32'ha2);
    repeat (3) @(posedge clk);
    chk("limp_dis", 32'h0, {31'h0, limp});
    wd_limp <= 1'b0;
    therm <= 1'b1;
    check_state(lin_ctrl_pkg::S_FSAFE);
    chk("attn", 32'h0, {31'h0, en_lvl});
    chk("ext_wdr", 32'h0, {31'h0, ext_wdr_n});
    ahb(1'b0, A_STAT, 32'h0); chk("stat", 32'h45, {24'h0, rd[7:0] & 8'h47});
    therm <= 1'b0;
    ahb(1'b1, A_STAT, 32'h40); repeat (2) @(posedge clk);
    chk("attn_off", 32'h1, {31'h0, en_lvl});
    stop_test();
  end
endmodule
